/* rtl/isa_pkg.sv */
// Constants shared by the inertial sensor serial access block
package isa_pkg;

  // Frame and register geometry
  localparam int ISA_FRAME_BITS = 16;
  localparam int ISA_NUM_WORDS = 32;
  localparam int ISA_NUM_OUT = 9;
  localparam int ISA_DATA_BITS = 14;
  localparam logic [3:0] ISA_FIRST_BIT = 4'h0;
  localparam logic [3:0] ISA_LAST_BIT = 4'hF;

  // Frame fields
  localparam int ISA_RW_BIT = 15;
  localparam int ISA_RADDR_HI = 14;
  localparam int ISA_WADDR_HI = 13;
  localparam int ISA_ADDR_LO = 8;
  localparam int ISA_WDATA_HI = 7;

  // Output data word flags
  localparam int ISA_ND_BIT = 15;
  localparam int ISA_EA_BIT = 14;

  // Word indices (byte address divided by two)
  localparam logic [4:0] ISA_FLASH_WRITE_COUNTER_IDX = 5'h00;
  localparam logic [4:0] ISA_GPIO_IDX = 5'h19;
  localparam logic [4:0] ISA_MSC_IDX = 5'h1A;
  localparam logic [4:0] ISA_SMPL_IDX = 5'h1B;
  localparam logic [4:0] ISA_AVG_IDX = 5'h1C;
  localparam logic [4:0] ISA_GLOB_IDX = 5'h1F;

  // Words that accept writes, and words that hold sample results
  localparam logic [31:0] ISA_WR_MASK = 32'hFFFF_2000;
  localparam logic [31:0] ISA_OUT_MASK = 32'h0000_0FE6;
  localparam logic [4:0] ISA_OUT_IDX [ISA_NUM_OUT] = '{
    5'h01, 5'h02, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B
  };

  // Reset values
  localparam logic [15:0] ISA_MSC_RST = 16'h0006;
  localparam logic [15:0] ISA_SMPL_RST = 16'h0001;
  localparam logic [15:0] ISA_AVG_RST = 16'h0402;

  // Auxiliary line control word fields
  localparam int ISA_GPIO_DIR_C = 0;
  localparam int ISA_GPIO_DIR_D = 1;
  localparam int ISA_GPIO_SYNC_EN = 2;
  localparam int ISA_GPIO_IN_C = 4;
  localparam int ISA_GPIO_IN_D = 5;
  localparam int ISA_GPIO_OUT_C = 8;
  localparam int ISA_GPIO_OUT_D = 9;

  // Backup command: low byte of command word, this data bit
  localparam int ISA_FLASH_CMD_BIT = 0;

  // Timing
  localparam longint ISA_CLK_HZ = 100_000_000;
  localparam longint ISA_RATE_MILLI_SPS = 819_200;
  localparam int ISA_SAMPLE_CYC = int'((ISA_CLK_HZ * 1000) /
    ISA_RATE_MILLI_SPS);
  localparam longint ISA_FLASH_MS = 50;
  localparam int ISA_FLASH_CYC = int'((ISA_CLK_HZ * ISA_FLASH_MS + 999) /
    1000);
  localparam longint ISA_DRDY_NS = 50;
  localparam int ISA_DRDY_CYC = int'((ISA_DRDY_NS * ISA_CLK_HZ +
    999_999_999) / 1_000_000_000);

endpackage

/* rtl/isa_sync2.sv */
// Two flip-flop synchroniser for levels entering the reference clock domain
`timescale 1ns/1ps
module isa_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule // isa_sync2

/* rtl/isa_spi_slave.sv */
// Serial slave port, user registers, sampling and backup of the sensor
`timescale 1ns/1ps
module isa_spi_slave #(
  parameter int SAMPLE_PERIOD_CYC = isa_pkg::ISA_SAMPLE_CYC,
  parameter int FLASH_BUSY_CYC = isa_pkg::ISA_FLASH_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  input wire logic [isa_pkg::ISA_NUM_OUT*isa_pkg::ISA_DATA_BITS-1:0]
    sensor_results,
  output logic data_ready_line_out,
  output logic data_ready_line_oe_n,
  input wire logic aux_digital_line_c_in,
  output logic aux_digital_line_c_out,
  output logic aux_digital_line_c_oe_n,
  input wire logic aux_line_or_sync_clock_in_in,
  output logic aux_line_or_sync_clock_in_out,
  output logic aux_line_or_sync_clock_in_oe_n,
  output logic flash_busy
);

  // ---------------- Link side, serial clock domain ----------------
  logic frame_clr;
  logic [3:0] bit_cnt;
  logic [14:0] rx_shift;
  logic [15:0] rx_hold;
  logic rx_toggle;
  logic frame_last;
  logic frame_first;
  logic [15:0] tx_shift;
  logic [15:0] tx_word;

  assign frame_clr = rst | cs_n;
  assign frame_last = (bit_cnt == isa_pkg::ISA_LAST_BIT);
  assign frame_first = (bit_cnt == isa_pkg::ISA_FIRST_BIT);

  always_ff @(posedge sclk or posedge frame_clr) begin
    if (frame_clr) begin
      bit_cnt <= '0;
      rx_shift <= '0;
    end else begin
      bit_cnt <= bit_cnt + 4'h1;
      rx_shift <= {rx_shift[13:0], din};
    end
  end

  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      rx_hold <= '0;
      rx_toggle <= 1'b0;
    end else if (frame_last) begin
      rx_hold <= {rx_shift, din};
      rx_toggle <= ~rx_toggle;
    end
  end

  // reply shifts while the next command arrives
  // tx_word settles during the stall gap, so it is quasi-static here
  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      dout <= 1'b0;
      tx_shift <= '0;
    end else if (frame_first) begin
      dout <= tx_word[15];
      tx_shift <= {tx_word[14:0], 1'b0};
    end else begin
      dout <= tx_shift[15];
      tx_shift <= {tx_shift[14:0], 1'b0};
    end
  end

  // ---------------- Reference clock domain ----------------
  logic toggle_s;
  logic aux_c_s;
  logic aux_d_s;
  logic toggle_seen;
  logic sync_prev;

  isa_sync2 #(
    .WIDTH(3)
  ) u_sync (
    .clk(ref_clk),
    .rst(rst),
    .d({rx_toggle, aux_digital_line_c_in, aux_line_or_sync_clock_in_in}),
    .q({toggle_s, aux_c_s, aux_d_s})
  );

  logic [15:0] regs [isa_pkg::ISA_NUM_WORDS];

  // Frame decode
  logic frame_evt;
  logic is_write;
  logic [5:0] waddr;
  logic [4:0] widx;
  logic wbyte;
  logic [7:0] wdata;
  logic [6:0] raddr;
  logic [4:0] ridx;
  logic rmapped;
  logic wr_ok;
  logic rd_evt;
  logic nd_clear;
  logic [15:0] gpio_view;
  logic [15:0] rd_val;
  logic flash_req;
  logic flash_done;
  logic sync_en;
  logic sync_rise;
  logic timer_done;
  logic sample_tick;

  assign frame_evt = toggle_s ^ toggle_seen;
  assign is_write = rx_hold[isa_pkg::ISA_RW_BIT];
  // byte address selects word and half
  assign waddr = rx_hold[isa_pkg::ISA_WADDR_HI:isa_pkg::ISA_ADDR_LO];
  assign widx = waddr[5:1];
  assign wbyte = waddr[0];
  assign wdata = rx_hold[isa_pkg::ISA_WDATA_HI:0];
  assign raddr = rx_hold[isa_pkg::ISA_RADDR_HI:isa_pkg::ISA_ADDR_LO];
  assign ridx = raddr[5:1];
  assign rmapped = ~raddr[6];
  assign wr_ok = frame_evt & is_write & isa_pkg::ISA_WR_MASK[widx];
  assign rd_evt = frame_evt & ~is_write;
  assign nd_clear = rd_evt & rmapped & isa_pkg::ISA_OUT_MASK[ridx];

  // Aux line input levels replace two bits of the control word on read
  assign gpio_view = {regs[isa_pkg::ISA_GPIO_IDX][15:6], aux_d_s, aux_c_s,
    regs[isa_pkg::ISA_GPIO_IDX][3:0]};
  // Command word reads as zero, like addresses beyond the map
  assign rd_val = (!rmapped || ridx == isa_pkg::ISA_GLOB_IDX) ? 16'h0000 :
    (ridx == isa_pkg::ISA_GPIO_IDX) ? gpio_view : regs[ridx];

  assign flash_req = wr_ok && widx == isa_pkg::ISA_GLOB_IDX && !wbyte &&
    wdata[isa_pkg::ISA_FLASH_CMD_BIT];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      toggle_seen <= 1'b0;
      sync_prev <= 1'b0;
    end else begin
      toggle_seen <= toggle_s;
      sync_prev <= aux_d_s;
    end
  end

  // word returned in the following frame
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_word <= '0;
    end else if (rd_evt) begin
      tx_word <= rd_val;
    end else if (frame_evt) begin
      tx_word <= '0;
    end
  end

  // sync clock or internal timer paces sampling
  assign sync_en = regs[isa_pkg::ISA_GPIO_IDX][isa_pkg::ISA_GPIO_SYNC_EN];
  assign sync_rise = aux_d_s & ~sync_prev;
  logic [31:0] sample_cnt;
  assign timer_done = (sample_cnt == 32'(SAMPLE_PERIOD_CYC - 1));
  assign sample_tick = sync_en ? sync_rise : timer_done;

  always_ff @(posedge ref_clk) begin
    if (rst || timer_done) begin
      sample_cnt <= '0;
    end else begin
      sample_cnt <= sample_cnt + 32'h0000_0001;
    end
  end

  // New sample words, flag set and error flag clear
  logic [15:0] sample_word [isa_pkg::ISA_NUM_OUT];
  genvar k;
  generate
    for (k = 0; k < isa_pkg::ISA_NUM_OUT; k++) begin : g_word
      assign sample_word[k] = {1'b1, 1'b0,
        sensor_results[k*isa_pkg::ISA_DATA_BITS +: isa_pkg::ISA_DATA_BITS]};
    end
  endgenerate

  // Later assignments win: a sample arriving with a read keeps its flag
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < isa_pkg::ISA_NUM_WORDS; i++) begin
        regs[i] <= '0;
      end
      regs[isa_pkg::ISA_MSC_IDX] <= isa_pkg::ISA_MSC_RST;
      regs[isa_pkg::ISA_SMPL_IDX] <= isa_pkg::ISA_SMPL_RST;
      regs[isa_pkg::ISA_AVG_IDX] <= isa_pkg::ISA_AVG_RST;
    end else begin
      if (wr_ok && wbyte) begin
        regs[widx][15:8] <= wdata;
      end else if (wr_ok) begin
        regs[widx][7:0] <= wdata;
      end
      if (nd_clear) begin
        regs[ridx][isa_pkg::ISA_ND_BIT] <= 1'b0;
      end
      if (flash_done) begin
        regs[isa_pkg::ISA_FLASH_WRITE_COUNTER_IDX] <=
          regs[isa_pkg::ISA_FLASH_WRITE_COUNTER_IDX] + 16'h0001;
      end
      if (sample_tick) begin
        for (int j = 0; j < isa_pkg::ISA_NUM_OUT; j++) begin
          regs[isa_pkg::ISA_OUT_IDX[j]] <= sample_word[j];
        end
      end
    end
  end

  // backup busy for its full time; requests meanwhile are ignored
  logic [31:0] flash_write_counter;
  assign flash_done = flash_busy && flash_write_counter == 32'h0000_0000;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flash_busy <= 1'b0;
      flash_write_counter <= '0;
    end else if (flash_req && !flash_busy) begin
      flash_busy <= 1'b1;
      flash_write_counter <= 32'(FLASH_BUSY_CYC - 1);
    end else if (flash_done) begin
      flash_busy <= 1'b0;
    end else if (flash_busy) begin
      flash_write_counter <= flash_write_counter - 32'h0000_0001;
    end
  end

  logic [2:0] drdy_cnt;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      drdy_cnt <= '0;
      data_ready_line_out <= 1'b0;
    end else if (sample_tick) begin
      drdy_cnt <= 3'(isa_pkg::ISA_DRDY_CYC - 1);
      data_ready_line_out <= 1'b1;
    end else if (drdy_cnt != 3'h0) begin
      drdy_cnt <= drdy_cnt - 3'h1;
      data_ready_line_out <= 1'b1;
    end else begin
      data_ready_line_out <= 1'b0;
    end
  end

  // aux line direction; sync mode forces the fourth line to input
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      data_ready_line_oe_n <= 1'b1;
      aux_digital_line_c_out <= 1'b0;
      aux_digital_line_c_oe_n <= 1'b1;
      aux_line_or_sync_clock_in_out <= 1'b0;
      aux_line_or_sync_clock_in_oe_n <= 1'b1;
    end else begin
      data_ready_line_oe_n <= 1'b0;
      aux_digital_line_c_out <=
        regs[isa_pkg::ISA_GPIO_IDX][isa_pkg::ISA_GPIO_OUT_C];
      aux_digital_line_c_oe_n <=
        ~regs[isa_pkg::ISA_GPIO_IDX][isa_pkg::ISA_GPIO_DIR_C];
      aux_line_or_sync_clock_in_out <=
        regs[isa_pkg::ISA_GPIO_IDX][isa_pkg::ISA_GPIO_OUT_D];
      aux_line_or_sync_clock_in_oe_n <= sync_en |
        ~regs[isa_pkg::ISA_GPIO_IDX][isa_pkg::ISA_GPIO_DIR_D];
    end
  end

  // ---------------- Checks ----------------
  a_drdy_pulse_len: assert property (
    @(posedge ref_clk) disable iff (rst)
    sample_tick |=> data_ready_line_out [*5] ##1 !data_ready_line_out)
    else $error("data ready pulse length wrong");

  a_sample_nd_set: assert property (
    @(posedge ref_clk) disable iff (rst)
    sample_tick |=> regs[isa_pkg::ISA_OUT_IDX[0]][isa_pkg::ISA_ND_BIT])
    else $error("new sample flag not set after sample");

  a_read_nd_clear: assert property (
    @(posedge ref_clk) disable iff (rst)
    nd_clear && !sample_tick |=> !regs[$past(ridx)][isa_pkg::ISA_ND_BIT])
    else $error("new sample flag not cleared by read");

  a_write_commit: assert property (
    @(posedge ref_clk) disable iff (rst)
    wr_ok && !wbyte && !sample_tick |=> regs[$past(widx)][7:0] == $past(wdata))
    else $error("written byte not committed");

  a_write_ignored: assert property (
    @(posedge ref_clk) disable iff (rst)
    frame_evt && is_write && !isa_pkg::ISA_WR_MASK[widx] && !sample_tick &&
      !flash_done && !nd_clear |=> regs[$past(widx)] == $past(regs[widx]))
    else $error("read-only location was written");

  a_read_reply: assert property (
    @(posedge ref_clk) disable iff (rst)
    rd_evt |=> tx_word == $past(rd_val))
    else $error("read reply does not match register");

  a_flash_start: assert property (
    @(posedge ref_clk) disable iff (rst)
    flash_req && !flash_busy |=> flash_busy [*8])
    else $error("backup did not start or ended early");

  a_flash_count: assert property (
    @(posedge ref_clk) disable iff (rst)
    flash_done |=> regs[isa_pkg::ISA_FLASH_WRITE_COUNTER_IDX] ==
      $past(regs[isa_pkg::ISA_FLASH_WRITE_COUNTER_IDX]) + 16'h0001)
    else $error("flash write counter did not advance");

  a_timer_tick: assert property (
    @(posedge ref_clk) disable iff (rst)
    timer_done |=> sample_cnt == 32'h0000_0000)
    else $error("sample timer did not restart");

  a_frame_count: assert property (
    @(posedge sclk) disable iff (frame_clr)
    frame_last |=> frame_first)
    else $error("bit counter did not wrap after sixteen bits");

endmodule // isa_spi_slave

/* verif/isa_spi_master.sv */
// Master processor model that drives the sensor serial link
`timescale 1ns/1ps
module isa_spi_master (
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout
);
  // Half of the 160 ns link period
  localparam time HALF = 80ns;

  initial begin
    sclk = 1'b1;
    din = 1'b0;
    // Select rises after reset so the bit counter clears on a real edge
    #2;
    cs_n = 1'b1;
  end

  task automatic xfer(input logic [15:0] tx, input int nbits,
      output logic [15:0] rx);
    rx = 16'h0000;
    cs_n = 1'b0;
    #HALF;
    for (int i = 15; i > 15 - nbits; i--) begin
      sclk = 1'b0;
      din = tx[i];
      #HALF;
      sclk = 1'b1;
      rx[i] = dout;
      #HALF;
    end
    cs_n = 1'b1;
    // Released line shows the inverse, never a stale bit
    din = ~din;
    #9us;
  endtask
endmodule // isa_spi_master

/* verif/inertial_sensor_spi_slave_access_tb.sv */
// Self-checking bench for the inertial sensor serial slave
`timescale 1ns/1ps
module inertial_sensor_spi_slave_access_tb;
  localparam int SPER = 5000;
  localparam int FBUSY = 2000;
  localparam int LIMIT = 80000;
  typedef struct packed {
    logic [15:0] wr;
    logic [6:0] addr;
    logic [15:0] exp;
  } isa_row_t;
  logic ref_clk, rst, sclk, cs_n, din, dout, busy;
  logic drdy, drdy_oe_n, c_in, c_out, c_oe_n, d_in, d_out, d_oe_n;
  logic [125:0] sensor_results;
  logic [15:0] rx;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  isa_row_t rows [9] = '{
    '{16'h0000, 7'h34, 16'h0006}, '{16'h0000, 7'h37, 16'h0001},
    '{16'h0000, 7'h38, 16'h0402}, '{16'h0000, 7'h3E, 16'h0000},
    '{16'h0000, 7'h40, 16'h0000}, '{16'hA11F, 7'h21, 16'h1F00},
    '{16'hA0AA, 7'h20, 16'h1FAA}, '{16'h9C55, 7'h1C, 16'h0000},
    '{16'h9A33, 7'h1A, 16'h0033}
  };

  isa_spi_slave #(.SAMPLE_PERIOD_CYC(SPER), .FLASH_BUSY_CYC(FBUSY)) dut_u (
    .ref_clk(ref_clk),
    .rst(rst),
    .sclk(sclk),
    .cs_n(cs_n),
    .din(din),
    .dout(dout),
    .sensor_results(sensor_results),
    .data_ready_line_out(drdy),
    .data_ready_line_oe_n(drdy_oe_n),
    .aux_digital_line_c_in(c_in),
    .aux_digital_line_c_out(c_out),
    .aux_digital_line_c_oe_n(c_oe_n),
    .aux_line_or_sync_clock_in_in(d_in),
    .aux_line_or_sync_clock_in_out(d_out),
    .aux_line_or_sync_clock_in_oe_n(d_oe_n),
    .flash_busy(busy)
  );

  isa_spi_master mst_u (
    .sclk(sclk),
    .cs_n(cs_n),
    .din(din),
    .dout(dout)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp,
      input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    mst_u.xfer({1'b0, a, 8'h00}, 16, d);
    mst_u.xfer(16'h0000, 16, d);
  endtask

  // Cycles from the present edge to the next rise of data ready
  task automatic wait_drdy(output int k);
    k = 0;
    while (drdy !== 1'b0 && k < 9000) begin
      @(negedge ref_clk);
      k++;
    end
    while (drdy !== 1'b1 && k < 9000) begin
      @(negedge ref_clk);
      k++;
    end
  endtask

  initial begin
    // Late rise gives the link flops a clean reset edge
    rst = 1'b0;
    #1;
    rst = 1'b1;
    c_in = 1'b0;
    d_in = 1'b0;
    sensor_results = '0;
    sensor_results[28 +: 14] = 14'h2345;
    repeat (2) @(negedge ref_clk);
    chk("dout in reset", 16'h0000, {15'h0, dout});
    chk("drdy oe_n in reset", 16'h0001, {15'h0, drdy_oe_n});
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk("drdy oe_n", 16'h0000, {15'h0, drdy_oe_n});
    $display("reset test done");
    foreach (rows[i]) begin
      mst_u.xfer(rows[i].wr, 16, rx);
      rd(rows[i].addr, rx);
      chk("row word", rows[i].exp, rx);
      $display("row %0d done", i);
    end
    wait_drdy(n);
    wait_drdy(n);
    chk("sample period", 16'(SPER), n[15:0]);
    n = 0;
    while (drdy === 1'b1 && n < 50) begin
      @(negedge ref_clk);
      n++;
    end
    chk("drdy width", 16'(isa_pkg::ISA_DRDY_CYC), n[15:0]);
    mst_u.xfer(16'h0A00, 16, rx);
    mst_u.xfer(16'h0A00, 16, rx);
    chk("fresh sample", 16'hA345, rx);
    mst_u.xfer(16'h0000, 16, rx);
    chk("flag cleared", 16'h2345, rx);
    $display("sample test done");
    mst_u.xfer(16'h9A77, 8, rx);
    rd(7'h1A, rx);
    chk("partial frame", 16'h0033, rx);
    $display("partial frame test done");
    // master chooses when to back up
    fork
      begin
        mst_u.xfer(16'hBE01, 16, rx);
        mst_u.xfer(16'hBE01, 16, rx);
      end
      begin
        n = 0;
        while (busy !== 1'b1 && n < 2000) begin
          @(negedge ref_clk);
          n++;
        end
        n = 0;
        while (busy === 1'b1 && n < 9000) begin
          @(negedge ref_clk);
          n++;
        end
      end
    join
    chk("busy cycles", 16'(FBUSY), n[15:0]);
    rd(7'h00, rx);
    chk("flash count", 16'h0001, rx);
    $display("backup test done");
    mst_u.xfer(16'hB203, 16, rx);
    mst_u.xfer(16'hB302, 16, rx);
    chk("aux pins", 16'h0001, {12'h0, c_oe_n, c_out, d_oe_n, d_out});
    mst_u.xfer(16'hB204, 16, rx);
    chk("sync oe_n", 16'h0001, {15'h0, d_oe_n});
    d_in = 1'b1;
    n = 0;
    while (drdy !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    chk("sync tick", 16'h0001, {15'h0, drdy});
    $display("aux line test done");
    finish_test();
  end
endmodule // inertial_sensor_spi_slave_access_tb
